// ---- irf_pkg.sv ----
package irf_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] ADDR_EXT_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_TMR_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_EXT_ENABLE = 4'h2;
    localparam logic [3:0] ADDR_TMR_ENABLE = 4'h3;
    localparam logic [3:0] ADDR_EDGE_SEL = 4'h4;
    localparam logic [3:0] ADDR_PORT_MODE = 4'h5;
    localparam logic [3:0] ADDR_SYS_CTRL = 4'h6;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

    // Layout of the external-request flag, enable, edge-select and port-mode registers
    localparam logic [7:0] EXT_FLAG_MASK = 8'h33;
    localparam logic [7:0] EXT_FIXED_ONES = 8'hc0;
    localparam logic [7:0] EXT_ENABLE_FIXED_ONES = 8'hc0;
    localparam logic [7:0] EDGE_SEL_MASK = 8'h13;
    localparam logic [7:0] EDGE_SEL_FIXED_ONES = 8'hec;
    localparam logic [7:0] PORT_MODE_MASK = 8'h33;

    // Layout of the timer and transfer flag register
    localparam logic [7:0] TMR_FLAG_MASK = 8'h3f;
    localparam int DT_BIT = 5;

    // System control bits in the local control register
    localparam int SYS_DIRECT_TRANSFER_ON_BIT = 0;
    localparam int SYS_LOW_SPEED_ON_BIT = 1;
    localparam logic [7:0] SYS_CTRL_MASK = 8'h03;

    // Interrupt status layout: bit 0 external, bit 1 timer or transfer
    localparam logic [7:0] IRQ_STAT_MASK = 8'h03;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_MODE = 8'h00;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
endpackage

// ---- irf_pin_edge.sv ----
`timescale 1ns/1ps
// Synchronises one pin and reports the selected edge as a one-cycle pulse
module irf_pin_edge (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Pin and edge control
    input wire logic i_pin,
    input wire logic i_rise_sel,
    input wire logic i_enable,
    // Detected edge
    output logic o_edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } irf_edge_state_t;

    irf_edge_state_t st_r;
    irf_edge_state_t st_nxt;

    // Next state: meta only feeds sync, never the edge logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = i_pin;
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
    end

    // Pins idle high, so reset to one avoids a false rising edge
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= '{meta: 1'b1, sync: 1'b1, last: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    // [R17] Synchronised edge pulse
    assign o_edge = i_enable & (i_rise_sel ? (st_r.sync & ~st_r.last) : (~st_r.sync & st_r.last));
endmodule

// ---- irf_request_flags.sv ----
`timescale 1ns/1ps
// Function
// [R1] Eight-bit read/write external request flag register.
// [R2] External register bits 7 and 6 read one, ignore writes.
// [R3] External register bits 3 and 2 read zero, ignore writes.
// [R4] Line flags set on selected edge when pin is in interrupt mode.
// [R5] Writing zero to a flag clears it.
// [R6] Writing one to a flag changes nothing.
// [R7] Processor acceptance does not clear flags.
// [R8] Second eight-bit register holds transfer flag and timer A-E overflow flags.
// [R9] Second register bits 7 and 6 read zero; software writes zero.
// [R10] Transfer flag sets on sleep-driven direct transfer with proper enables.
// [R11] Bits 4 to 0 set on timer E to A overflow requests.
// [R12] All flags read zero after reset.
// [R13] Flag requests processor only when its enable bit is one.
// [R14] Lines 4, 1, 0 select rising or falling edge.
// [R15] Line 5 detects falling edges only.
// [R16] Hardware set beats a same-cycle software clear.
// [R17] Pins synchronised before edge detection; edge sets flag in one cycle.
module irf_request_flags (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // External interrupt pins, active low lines
    input wire logic i_ext_int_pin_0,
    input wire logic i_ext_int_pin_1,
    input wire logic i_ext_int_pin_4,
    input wire logic i_ext_int_pin_5,
    // Timer overflow requests, bit 0 is timer A
    input wire logic [4:0] i_timer_ovf,
    // Power-mode controller: sleep in subactive mode leading to direct transfer
    input wire logic i_sleep_direct_transfer,
    // Requests toward the processor
    output logic [7:0] o_ext_request,
    output logic [7:0] o_tmr_request,
    output logic o_irq
);
    typedef struct packed {
        logic [7:0] ext_flags;
        logic [7:0] tmr_flags;
        logic [7:0] ext_enable;
        logic [7:0] tmr_enable;
        logic [7:0] edge_sel;
        logic [7:0] port_mode;
        logic [7:0] sys_ctrl;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [7:0] rdata;
        logic [7:0] ext_req;
        logic [7:0] tmr_req;
    } irf_state_t;

    irf_state_t st_r;
    irf_state_t st_nxt;
    logic [3:0] line_edge;
    logic [7:0] ext_set;
    logic [7:0] tmr_set;
    logic [7:0] ext_set_word;
    logic [7:0] tmr_set_word;
    logic [7:0] ext_pend;
    logic [7:0] tmr_pend;
    logic [7:0] stat_set;
    logic dt_cond;

    // Edge detectors for lines 0, 1, 4 with selectable edge
    // [R14] Per-line edge select
    irf_pin_edge u_edge0 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_ext_int_pin_0),
        .i_rise_sel(st_r.edge_sel[0]),
        .i_enable(st_r.port_mode[0]),
        .o_edge(line_edge[0])
    );
    irf_pin_edge u_edge1 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_ext_int_pin_1),
        .i_rise_sel(st_r.edge_sel[1]),
        .i_enable(st_r.port_mode[1]),
        .o_edge(line_edge[1])
    );
    irf_pin_edge u_edge4 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_ext_int_pin_4),
        .i_rise_sel(st_r.edge_sel[4]),
        .i_enable(st_r.port_mode[4]),
        .o_edge(line_edge[2])
    );
    // [R15] Line 5 falling edge only
    irf_pin_edge u_edge5 (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_ext_int_pin_5),
        .i_rise_sel(1'b0),
        .i_enable(st_r.port_mode[5]),
        .o_edge(line_edge[3])
    );

    // Hardware set vectors
    always_comb begin
        // [R4] Edge in interrupt mode sets flag
        ext_set = {2'b00, line_edge[3], line_edge[2], 2'b00, line_edge[1], line_edge[0]};
        // [R10] Direct transfer condition
        dt_cond = i_sleep_direct_transfer & st_r.sys_ctrl[irf_pkg::SYS_DIRECT_TRANSFER_ON_BIT]
                  & ~st_r.sys_ctrl[irf_pkg::SYS_LOW_SPEED_ON_BIT] & st_r.tmr_enable[irf_pkg::DT_BIT];
        // [R11] Timer overflow sets
        tmr_set = {2'b00, dt_cond, i_timer_ovf};
    end

    // Flag, register and request next state
    always_comb begin
        st_nxt = st_r;
        ext_set_word = st_r.ext_flags;
        tmr_set_word = st_r.tmr_flags;
        if (i_wr) begin
            unique case (i_addr)
                irf_pkg::ADDR_EXT_FLAGS: begin
                    // [R5] Zero clears; [R6] one keeps
                    ext_set_word = st_r.ext_flags & (i_wdata | ~irf_pkg::EXT_FLAG_MASK);
                end
                irf_pkg::ADDR_TMR_FLAGS: begin
                    // [R9] Reserved bits stay zero
                    tmr_set_word = st_r.tmr_flags & (i_wdata | ~irf_pkg::TMR_FLAG_MASK);
                end
                irf_pkg::ADDR_EXT_ENABLE: begin
                    st_nxt.ext_enable = i_wdata & ~irf_pkg::EXT_ENABLE_FIXED_ONES;
                end
                irf_pkg::ADDR_TMR_ENABLE: begin
                    st_nxt.tmr_enable = i_wdata;
                end
                irf_pkg::ADDR_EDGE_SEL: begin
                    st_nxt.edge_sel = i_wdata & irf_pkg::EDGE_SEL_MASK;
                end
                irf_pkg::ADDR_PORT_MODE: begin
                    st_nxt.port_mode = i_wdata & irf_pkg::PORT_MODE_MASK;
                end
                irf_pkg::ADDR_SYS_CTRL: begin
                    st_nxt.sys_ctrl = i_wdata & irf_pkg::SYS_CTRL_MASK;
                end
                irf_pkg::ADDR_IRQ_STATUS: begin
                    st_nxt.irq_status = st_r.irq_status & ~i_wdata;
                end
                irf_pkg::ADDR_IRQ_MASK: begin
                    st_nxt.irq_mask = i_wdata & irf_pkg::IRQ_STAT_MASK;
                end
                default: begin
                end
            endcase
        end
        // [R16] Set wins over clear; [R7] only software clears
        st_nxt.ext_flags = (ext_set_word | ext_set) & irf_pkg::EXT_FLAG_MASK;
        st_nxt.tmr_flags = (tmr_set_word | tmr_set) & irf_pkg::TMR_FLAG_MASK;
        // [R13] Enable gates request
        ext_pend = st_r.ext_flags & st_r.ext_enable;
        tmr_pend = st_r.tmr_flags & st_r.tmr_enable & irf_pkg::TMR_FLAG_MASK;
        st_nxt.ext_req = ext_pend;
        st_nxt.tmr_req = tmr_pend;
        // Status sets while any request is pending; set wins over write-one clear
        stat_set = {6'h00, |tmr_pend, |ext_pend};
        st_nxt.irq_status = st_nxt.irq_status | stat_set;
        // Read data registered for the next cycle
        st_nxt.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                // [R1] [R2] [R3] External flags with fixed reserved bits
                irf_pkg::ADDR_EXT_FLAGS: st_nxt.rdata = st_r.ext_flags | irf_pkg::EXT_FIXED_ONES;
                // [R8] Transfer and timer flags, reserved bits read zero
                irf_pkg::ADDR_TMR_FLAGS: st_nxt.rdata = st_r.tmr_flags;
                irf_pkg::ADDR_EXT_ENABLE: st_nxt.rdata = st_r.ext_enable | irf_pkg::EXT_ENABLE_FIXED_ONES;
                irf_pkg::ADDR_TMR_ENABLE: st_nxt.rdata = st_r.tmr_enable;
                irf_pkg::ADDR_EDGE_SEL: st_nxt.rdata = st_r.edge_sel | irf_pkg::EDGE_SEL_FIXED_ONES;
                irf_pkg::ADDR_PORT_MODE: st_nxt.rdata = st_r.port_mode;
                irf_pkg::ADDR_SYS_CTRL: st_nxt.rdata = st_r.sys_ctrl;
                irf_pkg::ADDR_IRQ_STATUS: st_nxt.rdata = st_r.irq_status;
                irf_pkg::ADDR_IRQ_MASK: st_nxt.rdata = st_r.irq_mask;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // [R12] Everything starts clear
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= '{default: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from registers; o_irq is the masked status
    assign o_rdata = st_r.rdata;
    assign o_ext_request = st_r.ext_req;
    assign o_tmr_request = st_r.tmr_req;
    assign o_irq = |(st_r.irq_status & st_r.irq_mask);
endmodule

// ---- irf_props.sv ----
`timescale 1ns/1ps
// Port-level checks of the request flag block
module irf_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Events and requests
    input wire logic [4:0] i_timer_ovf,
    input wire logic i_sleep_direct_transfer,
    input wire logic [7:0] o_ext_request,
    input wire logic [7:0] o_tmr_request,
    input wire logic o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Timer register read, and a cycle with no set event
    wire logic rd_t = i_rd && i_addr == 4'h1;
    wire logic quiet = i_timer_ovf == 5'h00 && !i_sleep_direct_transfer;
    AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data off slot");
    AST_EXT_FIXED: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[7:6] == 2'b11 && o_rdata[3:2] == 2'b00)
        else $error("fixed bits wrong");
    AST_TMR_RSVD: assert property (rd_t |=> o_rdata[7:6] == 2'b00) else $error("reserved bits set");
    AST_REQ_BITS: assert property ((o_ext_request & 8'hcc) == 8'h00 && o_tmr_request[7:6] == 2'b00)
        else $error("request without flag");
    // Set wins over a clear in the same cycle, so only a write in the next cycle can hide the event
    AST_TIMER_SET: assert property (i_timer_ovf != 5'h00 ##1 !i_wr ##1 rd_t |=>
        ($past(i_timer_ovf, 3) & ~o_rdata[4:0]) == 5'h00) else $error("overflow flag missing");
    AST_CLR_ZERO: assert property (i_wr && i_addr == 4'h1 && quiet ##1 quiet ##1 rd_t && quiet |=>
        (o_rdata & ~$past(i_wdata, 3) & 8'h3f) == 8'h00) else $error("flag survived clear");
    AST_REQ_FALL: assert property ($fell(|o_tmr_request) || $fell(|o_ext_request) |->
        $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3)) else $error("request dropped alone");
    AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
        else $error("irq dropped alone");
    // Main scenarios reached
    cover property (o_irq);
    cover property (o_ext_request == 8'h33);
    cover property (rd_t ##1 o_rdata[5]);
endmodule
bind irf_request_flags irf_props i_irf_props (.*);

// ---- testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench: register cycles, pin edges, timer and transfer events
module testbench;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0, sleep = 1'b0, irq;
    logic [3:0] addr = 4'h0;
    logic [3:0] pins = 4'hf; // Lines 5,4,1,0; idle high
    logic [4:0] ovf = 5'h00, r, r2;
    logic [7:0] wdata = 8'h00, rdata, ext_req, tmr_req;
    logic [7:0] exp_q[$];
    logic [7:0] rst_v[9] = '{8'hc0, 8'h00, 8'hc0, 8'h00, 8'hec, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [31:0] seed = 32'hf2c0bafa;
    int failures = 0, tests_run = 0;
    irf_request_flags i_irf_request_flags (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_ext_int_pin_0(pins[0]),
        .i_ext_int_pin_1(pins[1]), .i_ext_int_pin_4(pins[2]), .i_ext_int_pin_5(pins[3]),
        .i_timer_ovf(ovf), .i_sleep_direct_transfer(sleep), .o_ext_request(ext_req),
        .o_tmr_request(tmr_req), .o_irq(irq));
    // 200 MHz clock
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One register cycle; t gives {transfer, overflow} events in the same cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [5:0] t = 6'h00);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        i_wr <= w;
        i_rd <= !w;
        {sleep, ovf} <= t;
        if (!w) exp_q.push_back(d);
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        {sleep, ovf} <= 6'h00;
    endtask
    // Pin levels, then time for sync, flag, request and irq to settle
    task automatic pin(input logic [3:0] v);
        @(posedge i_clk);
        pins <= v;
        repeat (6) @(posedge i_clk);
    endtask
    task automatic outs(input logic [7:0] e, input logic [7:0] t, input logic q);
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        chk(ext_req, e);
        chk(tmr_req, t);
        chk({7'h00, irq}, {7'h00, q});
    endtask
    // Read data stands only in the cycle after the read; sampled mid-cycle
    always @(posedge i_clk) rd_d <= i_rd;
    always @(negedge i_clk) begin
        if (rd_d) begin
            chk(rdata, exp_q.pop_front());
        end
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        outs(8'h00, 8'h00, 1'b0);
        foreach (rst_v[k]) bus(1'b0, 4'(k), rst_v[k]);
        bus(1'b0, 4'hf, 8'h00);
        // Random overflow bursts, masked or not, then cleared
        bus(1'b1, 4'h3, 8'h3f);
        repeat (6) begin
            seed = xs(seed);
            r = seed[4:0];
            r2 = seed[12:8];
            bus(1'b1, 4'h8, {6'h00, seed[16], 1'b0});
            bus(1'b1, 4'hf, 8'hff, {1'b0, r});
            bus(1'b0, 4'h1, {3'h0, r});
            // Only zeros ever go to the reserved timer bits
            bus(1'b1, 4'h1, 8'h3f);
            bus(1'b0, 4'h1, {3'h0, r});
            outs(8'h00, {3'h0, r}, seed[16] && r != 5'h00);
            bus(1'b1, 4'h1, 8'h3f & ~{3'h0, r}, {1'b0, r2});
            bus(1'b0, 4'h1, {3'h0, r2});
            bus(1'b1, 4'h1, 8'h00);
            bus(1'b0, 4'h1, 8'h00);
            bus(1'b1, 4'h7, 8'hff);
            outs(8'h00, 8'h00, 1'b0);
        end
        // Direct transfer counts only with low speed off
        bus(1'b1, 4'h6, 8'h03);
        bus(1'b1, 4'hf, 8'hff, 6'h20);
        bus(1'b0, 4'h1, 8'h00);
        bus(1'b1, 4'h6, 8'h01);
        bus(1'b1, 4'hf, 8'hff, 6'h20);
        bus(1'b0, 4'h1, 8'h20);
        bus(1'b1, 4'h1, 8'h00);
        // Pin edges ignored until interrupt mode, then per selected edge
        pin(4'h0);
        pin(4'hf);
        bus(1'b0, 4'h0, 8'hc0);
        bus(1'b1, 4'h5, 8'h33);
        bus(1'b1, 4'h2, 8'h33);
        bus(1'b1, 4'h8, 8'h01);
        bus(1'b1, 4'h4, 8'h11);
        bus(1'b0, 4'h4, 8'hfd);
        pin(4'h0);
        bus(1'b0, 4'h0, 8'he2);
        pin(4'hf);
        bus(1'b1, 4'h0, 8'hff);
        bus(1'b0, 4'h0, 8'hf3);
        outs(8'h33, 8'h00, 1'b1);
        bus(1'b1, 4'h0, 8'h00);
        bus(1'b0, 4'h0, 8'hc0);
        bus(1'b1, 4'h7, 8'hff);
        outs(8'h00, 8'h00, 1'b0);
        end_of_test();
    end
    // Watchdog well past the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        end_of_test();
    end
endmodule
